// >>> logic/fpga_gpio_io_logic.sv
`timescale 1ns/1ps
module fpga_gpio_io_logic (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        config_done_i,
  input  wire logic        in_clk_i,
  input  wire logic        out_clk_i,
  input  wire logic        clk_tree_i,
  input  wire logic [3:0]  drive_lanes_i,
  input  wire logic        core_oe_i,
  output logic      [3:0]  capture_lanes_o,
  output logic             alternate_function_path_o,
  input  wire logic        delay_adjust_enable_i,
  input  wire logic        delay_step_direction_i,
  input  wire logic        delay_counter_clear_i,
  input  wire logic        pad_in_i,
  output logic             pad_out_o,
  output logic             pad_oe_o,
  output logic             weak_pull_up_o,
  output logic             weak_pull_down_o,
  output logic      [5:0]  in_static_tap_o,
  output logic      [5:0]  in_dynamic_tap_o,
  output logic      [5:0]  out_static_tap_o
);
  import io_cell_pkg::*;

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic [31:0]  ctrl;
  logic [31:0]  dly;
  logic [5:0]   dyn_tap;
  logic         bus_req;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
      dly  <= DELAY_RESET;
    end else if (bus_req && wb_we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b] && wb_adr_i == CTRL_ADDR) begin
          ctrl[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
        if (wb_sel_i[b] && wb_adr_i == DELAY_ADDR) begin
          dly[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        CTRL_ADDR:   wb_dat_o <= ctrl;
        DELAY_ADDR:  wb_dat_o <= dly;
        STATUS_ADDR: wb_dat_o <= {18'h0, config_done_i, pad_in_i,
                                  capture_lanes_o, 2'h0, dyn_tap};
        default:     wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Configuration decode
  // ------------------------------------------------------------
  pin_mode_type mode;
  align_type    align;
  pin_kind_type kind;
  logic         in_reg_en;
  logic         out_reg_en;
  logic         invert;
  logic         dual_edge_io;
  logic         serdes;
  logic         used;
  logic         fast_pin;
  logic         dyn_on;
  logic         rx_en;
  logic         tx_en;

  assign mode       = pin_mode_type'(ctrl[CTRL_MODE_LSB +: 2]);
  assign align      = align_type'(ctrl[CTRL_ALIGN_LSB +: 2]);
  assign kind       = pin_kind_type'(ctrl[CTRL_KIND_LSB +: 2]);
  assign in_reg_en  = ctrl[CTRL_IN_REG];
  assign out_reg_en = ctrl[CTRL_OUT_REG];
  assign invert     = ctrl[CTRL_INVERT];
  assign dual_edge_io       = ctrl[CTRL_DUAL_EDGE_IO];
  assign used       = ctrl[CTRL_USED];
  assign fast_pin   = kind != KIND_HV;
  assign serdes     = ctrl[CTRL_SERDES] && fast_pin;
  assign dyn_on     = dly[DLY_DYN] && fast_pin;
  assign rx_en      = used && (mode == MODE_INPUT || mode == MODE_BIDIR);
  assign tx_en      = used && (mode == MODE_OUTPUT || mode == MODE_BIDIR);

  // ------------------------------------------------------------
  // Clock edge detection
  // ------------------------------------------------------------
  logic in_clk_q;
  logic out_clk_q;
  logic in_rise;
  logic in_fall;
  logic out_rise;
  logic out_fall;
  logic in_edge;
  logic out_edge;
  logic oe_edge;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_clk_q  <= 1'b0;
      out_clk_q <= 1'b0;
    end else begin
      in_clk_q  <= in_clk_i;
      out_clk_q <= out_clk_i;
    end
  end

  assign in_rise  = in_clk_i && !in_clk_q;
  assign in_fall  = !in_clk_i && in_clk_q;
  assign out_rise = out_clk_i && !out_clk_q;
  assign out_fall = !out_clk_i && out_clk_q;
  assign in_edge  = ctrl[CTRL_IN_FALL] ? in_fall : in_rise;
  assign out_edge = ctrl[CTRL_OUT_FALL] ? out_fall : out_rise;
  assign oe_edge  = ctrl[CTRL_OE_FALL] ? out_fall : out_rise;

  // ------------------------------------------------------------
  // Receive path
  // ------------------------------------------------------------
  logic       rise_cap;
  logic       fall_cap;
  logic       in_q;
  logic [3:0] des_sh;
  logic [1:0] des_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_cap <= 1'b0;
      fall_cap <= 1'b0;
      in_q     <= 1'b0;
    end else if (rx_en) begin
      if (in_rise) begin
        rise_cap <= pad_in_i;
      end
      if (in_fall) begin
        fall_cap <= pad_in_i;
      end
      if (in_edge) begin
        in_q <= pad_in_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      des_sh  <= 4'h0;
      des_cnt <= 2'h0;
    end else if (rx_en && serdes && in_rise) begin
      des_sh  <= {pad_in_i, des_sh[3:1]};
      des_cnt <= des_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_lanes_o <= 4'h0;
    end else if (rx_en) begin
      if (serdes) begin
        if (in_rise && des_cnt == 2'h3) begin
          capture_lanes_o <= {pad_in_i, des_sh[3:1]};
        end
      end else if (dual_edge_io) begin
        case (align)
          ALIGN_NORMAL: begin
            if (in_rise) begin
              capture_lanes_o[0] <= pad_in_i;
            end
            if (in_fall) begin
              capture_lanes_o[1] <= pad_in_i;
            end
          end
          ALIGN_RESYNC: begin
            if (in_rise) begin
              capture_lanes_o[0] <= pad_in_i;
              capture_lanes_o[1] <= fall_cap;
            end
          end
          default: begin
            if (in_rise) begin
              capture_lanes_o[0] <= rise_cap;
              capture_lanes_o[1] <= fall_cap;
            end
          end
        endcase
      end else begin
        capture_lanes_o[0] <= in_reg_en ? in_q : pad_in_i;
      end
    end
  end

  assign alternate_function_path_o = ctrl[CTRL_ALT] && pad_in_i;

  // ------------------------------------------------------------
  // Drive path
  // ------------------------------------------------------------
  logic       drive_q;
  logic       oe_q;
  logic       dr_rise;
  logic       dr_fall;
  logic       fall_hold;
  logic [3:0] ser_sh;
  logic [1:0] ser_cnt;
  logic       next_drive;
  logic       oe_val;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_q   <= 1'b0;
      oe_q      <= 1'b0;
      dr_rise   <= 1'b0;
      dr_fall   <= 1'b0;
      fall_hold <= 1'b0;
    end else if (tx_en) begin
      if (out_edge) begin
        drive_q <= drive_lanes_i[0];
      end
      if (oe_edge) begin
        oe_q <= core_oe_i;
      end
      if (out_rise) begin
        dr_rise   <= drive_lanes_i[0];
        fall_hold <= drive_lanes_i[1];
      end
      if (out_fall) begin
        dr_fall <= (align == ALIGN_NORMAL) ? drive_lanes_i[1] : fall_hold;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_sh  <= 4'h0;
      ser_cnt <= 2'h0;
    end else if (tx_en && serdes && out_rise) begin
      ser_cnt <= ser_cnt + 2'h1;
      if (ser_cnt == 2'h0) begin
        ser_sh <= drive_lanes_i;
      end else begin
        ser_sh <= {1'b0, ser_sh[3:1]};
      end
    end
  end

  always_comb begin
    if (serdes) begin
      next_drive = ser_sh[0];
    end else if (dual_edge_io) begin
      next_drive = (out_clk_q ? dr_rise : dr_fall) ^ invert;
    end else if (out_reg_en) begin
      next_drive = drive_q ^ invert;
    end else begin
      next_drive = drive_lanes_i[0];
    end
  end

  assign oe_val = out_reg_en ? oe_q : core_oe_i;

  always_comb begin
    pad_out_o = 1'b0;
    pad_oe_o  = 1'b0;
    if (config_done_i && used) begin
      case (mode)
        MODE_OUTPUT: begin
          pad_out_o = next_drive;
          pad_oe_o  = 1'b1;
        end
        MODE_BIDIR: begin
          pad_out_o = next_drive;
          pad_oe_o  = oe_val;
        end
        MODE_CLKOUT: begin
          pad_out_o = clk_tree_i;
          pad_oe_o  = 1'b1;
        end
        default: begin
          pad_out_o = 1'b0;
          pad_oe_o  = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pull control
  // ------------------------------------------------------------
  assign weak_pull_up_o   = !config_done_i ||
                            (!used && !ctrl[CTRL_PULL_DOWN]);
  assign weak_pull_down_o = config_done_i && !used && ctrl[CTRL_PULL_DOWN];

  // ------------------------------------------------------------
  // Delay chains
  // ------------------------------------------------------------
  logic [5:0] tap_max;

  assign tap_max = (kind == KIND_HS_DIFF) ? WIDE_TAP_MAX : NARROW_TAP_MAX;

  always_ff @(posedge clk_i) begin
    if (rst_i || delay_counter_clear_i) begin
      dyn_tap <= 6'h00;
    end else if (dyn_on && delay_adjust_enable_i) begin
      if (delay_step_direction_i && dyn_tap != WIDE_TAP_MAX) begin
        dyn_tap <= dyn_tap + 6'h01;
      end else if (!delay_step_direction_i && dyn_tap != 6'h00) begin
        dyn_tap <= dyn_tap - 6'h01;
      end
    end
  end

  assign in_dynamic_tap_o = dyn_on ? dyn_tap : 6'h00;
  assign in_static_tap_o  = (kind == KIND_HS_DIFF && dyn_on) ? 6'h00 :
                            (dly[DLY_IN_LSB +: TAP_W] & tap_max);
  assign out_static_tap_o = dly[DLY_OUT_LSB +: TAP_W] & tap_max;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_config_pull: assert property (!config_done_i |-> weak_pull_up_o && !pad_oe_o)
    else $error("pin not pulled up during configuration");
  chk_unused_pull: assert property (config_done_i && !used |->
      !pad_oe_o && (weak_pull_up_o != weak_pull_down_o))
    else $error("unused pin not tristate with one pull");
  chk_input_tristate: assert property (mode == MODE_INPUT |-> !pad_oe_o)
    else $error("input mode drives pad");
  chk_clock_forward: assert property (config_done_i && used && mode == MODE_CLKOUT
      |-> pad_oe_o && pad_out_o == clk_tree_i)
    else $error("clock not forwarded");
  chk_rise_lane: assert property (rx_en && dual_edge_io && !serdes && align == ALIGN_NORMAL
      && in_rise ##1 $stable(ctrl) |-> capture_lanes_o[0] == $past(pad_in_i))
    else $error("rising sample not on lane 0");
  chk_resync_lane: assert property (rx_en && dual_edge_io && !serdes && align == ALIGN_RESYNC
      && in_rise ##1 $stable(ctrl) |-> capture_lanes_o[1] == $past(fall_cap))
    else $error("resync falling sample misplaced");
  chk_out_invert: assert property (tx_en && config_done_i && out_reg_en && !dual_edge_io
      && !serdes && out_edge ##1 $stable(ctrl)
      |-> pad_out_o == ($past(drive_lanes_i[0]) ^ invert))
    else $error("registered drive value wrong");
  chk_tap_clear: assert property (delay_counter_clear_i |=> dyn_tap == 6'h00)
    else $error("delay counter not cleared");
  chk_tap_step: assert property (dyn_on && delay_adjust_enable_i && delay_step_direction_i
      && !delay_counter_clear_i && dyn_tap < WIDE_TAP_MAX
      |=> dyn_tap == $past(dyn_tap) + 6'h01)
    else $error("delay did not step up");
  chk_tap_top: assert property (dyn_tap == WIDE_TAP_MAX && !delay_counter_clear_i
      |=> dyn_tap != 6'h00)
    else $error("delay counter wrapped");
  chk_diff_excl: assert property (kind == KIND_HS_DIFF && dyn_on |-> in_static_tap_o == 6'h00)
    else $error("static and dynamic delay both active");
  chk_slow_no_dyn: assert property (kind == KIND_HV |-> in_dynamic_tap_o == 6'h00)
    else $error("dynamic delay on slow pin");
  chk_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one cycle");

endmodule // fpga_gpio_io_logic

// >>> logic/io_cell_pkg.sv
package io_cell_pkg;

  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [3:0]  CTRL_ADDR      = 4'h0;
  localparam logic [3:0]  DELAY_ADDR     = 4'h4;
  localparam logic [3:0]  STATUS_ADDR    = 4'h8;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] DELAY_RESET    = 32'h0000_0000;

  // --------------------------------------------------------------------
  // Control fields
  // --------------------------------------------------------------------
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_IN_REG    = 2;
  localparam int CTRL_OUT_REG   = 3;
  localparam int CTRL_IN_FALL   = 4;
  localparam int CTRL_OUT_FALL  = 5;
  localparam int CTRL_OE_FALL   = 6;
  localparam int CTRL_INVERT    = 7;
  localparam int CTRL_DUAL_EDGE_IO      = 8;
  localparam int CTRL_ALIGN_LSB = 9;
  localparam int CTRL_ALT       = 11;
  localparam int CTRL_PULL_DOWN = 12;
  localparam int CTRL_SERDES    = 13;
  localparam int CTRL_KIND_LSB  = 14;
  localparam int CTRL_USED      = 16;

  // --------------------------------------------------------------------
  // Delay and status fields
  // --------------------------------------------------------------------
  localparam int DLY_IN_LSB     = 0;
  localparam int DLY_OUT_LSB    = 8;
  localparam int DLY_DYN        = 16;
  localparam int ST_TAP_LSB     = 0;
  localparam int ST_LANE_LSB    = 8;
  localparam int ST_PAD         = 12;
  localparam int ST_CONFIG      = 13;

  localparam int TAP_W          = 6;
  localparam logic [5:0] NARROW_TAP_MAX = 6'h0F;
  localparam logic [5:0] WIDE_TAP_MAX   = 6'h3F;
  localparam int SERDES_RATIO   = 4;

  typedef enum logic [1:0] {
    MODE_INPUT  = 2'b00,
    MODE_OUTPUT = 2'b01,
    MODE_BIDIR  = 2'b10,
    MODE_CLKOUT = 2'b11
  } pin_mode_type;

  typedef enum logic [1:0] {
    ALIGN_NORMAL   = 2'b00,
    ALIGN_RESYNC   = 2'b01,
    ALIGN_PIPELINE = 2'b10,
    ALIGN_SPARE    = 2'b11
  } align_type;

  typedef enum logic [1:0] {
    KIND_HV      = 2'b00,
    KIND_HS_SE   = 2'b01,
    KIND_HS_DIFF = 2'b10,
    KIND_SPARE   = 2'b11
  } pin_kind_type;

endpackage

// >>> test/core_fabric_model.sv
`timescale 1ns/1ps
module core_fabric_model #(
  parameter int HALF = 4
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [3:0] data_i,
  input  wire logic       oe_i,
  output logic            core_clk_o,
  output logic      [3:0] drive_lanes_o,
  output logic            core_oe_o
);
  // ----------------------------------------
  // Core clock and drive data launch
  // ----------------------------------------
  int count;

  // Each level held HALF cycles, still when idle
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      count      <= 0;
      core_clk_o <= 1'b0;
    end else if (count == HALF - 1) begin
      count      <= 0;
      core_clk_o <= !core_clk_o;
    end else begin
      count <= count + 1;
    end
  end

  // Lanes change on the same cycle as each falling edge, and every cycle when idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_lanes_o <= 4'h0;
      core_oe_o     <= 1'b0;
    end else if (!run_i || (core_clk_o && count == HALF - 1)) begin
      drive_lanes_o <= data_i;
      core_oe_o     <= oe_i;
    end
  end
endmodule // core_fabric_model

// >>> test/test_fpga_gpio_io_logic.sv
`timescale 1ns/1ps
module test_fpga_gpio_io_logic;
  import io_cell_pkg::*;
  // ----------------------------------------
  // Wiring
  // ----------------------------------------
  localparam logic [31:0] USE = 32'h1 << CTRL_USED;
  localparam logic [31:0] IRG = 32'h1 << CTRL_IN_REG;
  localparam logic [31:0] ORG = 32'h1 << CTRL_OUT_REG;
  localparam logic [31:0] DDR = 32'h1 << CTRL_DUAL_EDGE_IO;
  localparam logic [31:0] DYN = 32'h1 << DLY_DYN;
  logic        clk, rst, cyc, stb, we, cd, run, oe, pad, en, up, clr;
  logic [3:0]  adr, dat4;
  logic [31:0] wd, q;
  wire  [31:0] rd;
  wire  [5:0]  ist, dyn, ost;
  wire  [3:0]  lanes, cap;
  wire         ack, alternate_function_path, po, poe, pu, pdn, cc, coe;
  int          errors, total_checks;

  fpga_gpio_io_logic dut_u (
    .clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .config_done_i(cd), .in_clk_i(cc),
    .out_clk_i(cc), .clk_tree_i(cc), .drive_lanes_i(lanes),
    .core_oe_i(coe), .capture_lanes_o(cap),
    .alternate_function_path_o(alternate_function_path), .delay_adjust_enable_i(en),
    .delay_step_direction_i(up), .delay_counter_clear_i(clr),
    .pad_in_i(pad), .pad_out_o(po), .pad_oe_o(poe),
    .weak_pull_up_o(pu), .weak_pull_down_o(pdn), .in_static_tap_o(ist),
    .in_dynamic_tap_o(dyn), .out_static_tap_o(ost));

  core_fabric_model #(.HALF(4)) fabric_u (
    .clk_i(clk), .rst_i(rst), .run_i(run), .data_i(dat4), .oe_i(oe),
    .core_clk_o(cc), .drive_lanes_o(lanes), .core_oe_o(coe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", s, e, g);
      errors++;
    end
  endtask

  task automatic stall;
    $display("[FAIL] wait bound expected event seen none");
    errors++;
    report_and_stop();
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    for (k = 0; k == 0 || (ack !== 1'b1 && k < 20); k++) @(negedge clk);
    @(posedge clk);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (k >= 20) stall();
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string s);
    wb(1'b0, a, 32'h0);
    check(s, e, q);
  endtask

  task automatic edge_at(input logic l, input int n);
    int k;
    @(negedge clk);
    for (k = 0; cc === l && k < 40; k++) @(negedge clk);
    for (k = k; cc !== l && k < 80; k++) @(negedge clk);
    if (k >= 80) stall();
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic stp(input logic l, input logic [1:0] m, input logic [1:0] e, input logic v);
    edge_at(l, 2);
    check("capture lanes", 32'(e), 32'(cap[1:0] & m));
    @(posedge clk);
    pad <= v;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdchk(CTRL_ADDR, CTRL_RESET, "ctrl");
    rdchk(DELAY_ADDR, DELAY_RESET, "delay");
    wb(1'b1, 4'hC, 32'hFFFF_FFFF);
    rdchk(4'hC, 32'h0, "unmapped");
    rdchk(CTRL_ADDR, CTRL_RESET, "ctrl kept");
    check("pad oe", 0, poe);
  endtask

  task automatic t_in;
    wb(1'b1, CTRL_ADDR, USE | IRG);
    check("config pull up", 1, pu);
    stp(1'b1, 2'b00, 2'b00, 1'b1);
    stp(1'b0, 2'b00, 2'b00, 1'b1);
    stp(1'b1, 2'b01, 2'b01, 1'b0);
    stp(1'b0, 2'b01, 2'b01, 1'b0);
    wb(1'b1, CTRL_ADDR, USE | IRG | (32'h1 << CTRL_IN_FALL));
    stp(1'b1, 2'b00, 2'b00, 1'b0);
    stp(1'b0, 2'b00, 2'b00, 1'b1);
    stp(1'b1, 2'b01, 2'b00, 1'b1);
    stp(1'b0, 2'b01, 2'b01, 1'b0);
    check("input mode oe", 0, poe);
    cd <= 1'b1;
  endtask

  task automatic t_alt;
    wb(1'b1, CTRL_ADDR, USE | (32'h1 << CTRL_ALT));
    pad <= 1'b1;
    @(negedge clk);
    check("alternate path", 1, alternate_function_path);
    @(posedge clk);
    pad <= 1'b0;
    @(negedge clk);
    check("alternate path", 0, alternate_function_path);
  endtask

  task automatic t_ddr_in;
    wb(1'b1, CTRL_ADDR, USE | IRG | DDR);
    stp(1'b0, 2'b00, 2'b00, 1'b1);
    stp(1'b1, 2'b00, 2'b00, 1'b0);
    stp(1'b0, 2'b11, 2'b01, 1'b1);
    stp(1'b1, 2'b11, 2'b01, 1'b1);
    stp(1'b0, 2'b11, 2'b11, 1'b0);
    wb(1'b1, CTRL_ADDR, USE | IRG | DDR | (32'(ALIGN_RESYNC) << CTRL_ALIGN_LSB));
    stp(1'b0, 2'b00, 2'b00, 1'b0);
    stp(1'b1, 2'b00, 2'b00, 1'b1);
    stp(1'b0, 2'b11, 2'b00, 1'b0);
    stp(1'b1, 2'b11, 2'b10, 1'b0);
  endtask

  task automatic t_out(input logic [31:0] c, input logic e);
    wb(1'b1, CTRL_ADDR, USE | ORG | c);
    dat4 <= 4'h1;
    oe   <= 1'b1;
    edge_at(1'b1, 2);
    edge_at(1'b1, 2);
    check("pad out high phase", 32'(e), po);
    check("pad oe", 1, poe);
    edge_at(1'b0, 2);
    check("pad out low phase", 32'(e ^ c[CTRL_DUAL_EDGE_IO]), po);
  endtask

  task automatic t_bidir;
    @(posedge clk);
    pad <= 1'b1;
    oe  <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("bidir receive", 1, cap[0]);
    edge_at(1'b1, 2);
    edge_at(1'b1, 2);
    check("bidir oe off", 0, poe);
  endtask

  task automatic t_pins;
    wb(1'b1, CTRL_ADDR, USE | 32'(MODE_CLKOUT));
    repeat (12) begin
      @(negedge clk);
      check("clock out", 32'(cc), po);
    end
    cd <= 1'b1;
    wb(1'b1, CTRL_ADDR, 32'h0);
    check("unused pull up", 2, {pu, pdn});
    check("unused oe", 0, poe);
    wb(1'b1, CTRL_ADDR, 32'h1 << CTRL_PULL_DOWN);
    check("unused pull down", 1, {pu, pdn});
  endtask

  task automatic t_dly(input pin_kind_type k, input logic [5:0] e);
    wb(1'b1, CTRL_ADDR, USE | (32'(k) << CTRL_KIND_LSB));
    wb(1'b1, DELAY_ADDR, DYN | 32'h3F3C);
    check("in static", 32'(e), ist);
    check("out static", 32'(k == KIND_HS_DIFF ? 6'h3F : 6'h0F), ost);
    en <= 1'b1;
    up <= 1'b1;
    repeat (70) @(posedge clk);
    check("tap top", k == KIND_HV ? 0 : WIDE_TAP_MAX, dyn);
    up <= 1'b0;
    repeat (70) @(posedge clk);
    check("tap floor", 0, dyn);
    up <= 1'b1;
    repeat (5) @(posedge clk);
    clr <= 1'b1;
    repeat (2) @(posedge clk);
    check("tap clear", 0, dyn);
    en  <= 1'b0;
    clr <= 1'b0;
  endtask

  initial begin
    {cyc, stb, we, cd, run, oe, pad, en, up, clr} = 10'h0;
    {adr, dat4, wd} = 40'h0;
    errors = 0;
    total_checks = 0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    t_regs();
    t_in();
    t_alt();
    t_ddr_in();
    t_out(32'(MODE_OUTPUT) | (32'h1 << CTRL_INVERT), 1'b0);
    t_out(32'(MODE_OUTPUT) | DDR, 1'b1);
    t_out(32'(MODE_BIDIR), 1'b1);
    t_bidir();
    t_pins();
    t_dly(KIND_HS_SE, 6'h0C);
    t_dly(KIND_HS_DIFF, 6'h00);
    t_dly(KIND_HV, 6'h0C);
    report_and_stop();
  end
endmodule // test_fpga_gpio_io_logic
